// >>> verilog/prr_defines.svh
// Offsets, field positions and timing counts for the row repair pair
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH
`define PRR_CLK_MHZ       10
`define PRR_T_PGM_MS      1000
`define PRR_T_PGM_CK      (`PRR_T_PGM_MS * 1000 * `PRR_CLK_MHZ)
`define PRR_T_EXIT_NS     15
`define PRR_T_EXIT_CK     ((`PRR_T_EXIT_NS * `PRR_CLK_MHZ + 999) / 1000)
`define PRR_T_LATCH_NS    20
`define PRR_T_LATCH_CK    ((`PRR_T_LATCH_NS * `PRR_CLK_MHZ + 999) / 1000)
`define PRR_T_PGMPST_US   50
`define PRR_T_PGMPST_CK   (`PRR_T_PGMPST_US * `PRR_CLK_MHZ)
`define PRR_MR0           3'h0
`define PRR_MR4           3'h4
`define PRR_MR4_SOFT      5
`define PRR_MR4_HARD      13
`define PRR_MPR_HARD      7
`define PRR_MPR_SOFT      6
`define PRR_KEY0          12'hCFF
`define PRR_KEY1          12'h7FF
`define PRR_KEY2          12'hBFF
`define PRR_KEY3          12'h3FF
`define PRR_ASSOC_MASK    20'h5E003
`define PRR_DQ_IDLE       8'hFF
`define PRR_DQ_SELECT     8'h00
`define PRR_REG_CTRL      4'h0
`define PRR_REG_TARGET    4'h4
`define PRR_REG_STATUS    4'h8
`define PRR_REG_FLAGS     4'hC
`define PRR_CTRL_START    0
`define PRR_CTRL_HARD     1
`define PRR_CTRL_WRA      2
`define PRR_CTRL_SEL      3
`define PRR_CTRL_MPR      4
`define PRR_CTRL_CLRSOFT  5
`define PRR_ST_BUSY       0
`define PRR_ST_DONE       1
`define PRR_ST_REFUSED    2
`endif

// >>> verilog/prr_pkg.sv
// Types and guard key decode shared by both ends
`include "prr_defines.svh"
package prr_pkg;
   typedef enum logic [2:0] {
      CMD_DES = 3'h0,
      CMD_MRS = 3'h1,
      CMD_ACT = 3'h2,
      CMD_WR  = 3'h3,
      CMD_WRA = 3'h4,
      CMD_PRE = 3'h5,
      CMD_REF = 3'h6,
      CMD_MPR = 3'h7
   } prr_cmd_t;

   typedef enum logic [7:0] {
      D_IDLE = 8'h01,
      D_KEY  = 8'h02,
      D_ARM  = 8'h04,
      D_ROW  = 8'h08,
      D_WLAT = 8'h10,
      D_DATA = 8'h20,
      D_PRE  = 8'h40,
      D_HOLD = 8'h80
   } prr_dstate_t;

   typedef enum logic [10:0] {
      C_IDLE  = 11'h001,
      C_ENTER = 11'h002,
      C_KEY   = 11'h004,
      C_ACT   = 11'h008,
      C_WR    = 11'h010,
      C_WLAT  = 11'h020,
      C_DQ    = 11'h040,
      C_REC   = 11'h080,
      C_EXIT  = 11'h100,
      C_POST  = 11'h200,
      C_MPR   = 11'h400
   } prr_cstate_t;

   function automatic logic [11:0] prr_key(input logic [1:0] idx);
      unique case (idx)
         2'h0: prr_key = `PRR_KEY0;
         2'h1: prr_key = `PRR_KEY1;
         2'h2: prr_key = `PRR_KEY2;
         2'h3: prr_key = `PRR_KEY3;
      endcase
   endfunction
endpackage

// >>> verilog/prr_if.sv
// Command, address and DQ bus between controller and DRAM repair logic
`timescale 1ns/1ns
`include "prr_defines.svh"
interface prr_if;
   import prr_pkg::*;
   prr_cmd_t    cmd;
   logic [1:0]  bg;
   logic [1:0]  ba;
   logic [17:0] addr;
   logic [7:0]  ctl_dq_o;
   logic        ctl_dq_oe;
   logic [7:0]  dev_dq_o;
   logic        dev_dq_oe;
   logic [7:0]  dq;

   // Undriven DQ floats to the terminated high level
   assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : `PRR_DQ_IDLE);

   modport ctl (output cmd, bg, ba, addr, ctl_dq_o, ctl_dq_oe, input dq);
   modport dev (input cmd, bg, ba, addr, dq, output dev_dq_o, dev_dq_oe);
endinterface

// >>> verilog/prr_dram_end.sv
// DRAM side row repair: entry, guard key, target capture, repair storage
`timescale 1ns/1ns
`include "prr_defines.svh"
module prr_dram_end
   import prr_pkg::*;
#(
   parameter int WL       = 9,
   parameter bit SUP_HARD = 1'b1,
   parameter bit SUP_SOFT = 1'b1
)(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_por_n,
   prr_if.dev               bus,
   input  wire logic [1:0]  i_look_bg,
   input  wire logic [1:0]  i_look_ba,
   input  wire logic [17:0] i_look_row,
   output logic             o_look_hit,
   output logic             o_look_lost,
   output logic [3:0]       o_soft_map,
   output logic [3:0]       o_hard_map,
   output logic             o_retain_lost
);
   localparam int WW = $clog2(WL + 1);

   prr_dstate_t   state_q;
   logic [1:0]    key_q;
   logic          hard_q;
   logic          wra_q;
   logic          low_q;
   logic [1:0]    bg_q;
   logic [1:0]    beat_q;
   logic [19:0]   seed_q;
   logic [WW-1:0] wcnt_q;
   logic [3:0]    soft_v_q;
   logic [3:0]    hard_v_q;
   logic [19:0]   soft_seed_q [4];
   logic [19:0]   hard_seed_q [4];
   logic          hit_q;
   logic          lost_q;
   logic          retain_lost_q;
   logic [7:0]    dq_q;
   logic          dq_oe_q;
   logic [2:0]    mr_sel;
   logic          is_mr4;
   logic          ent_soft;
   logic          ent_hard;
   logic          mr_exit;
   logic          key_ok;
   logic          commit;
   logic          dq_low;
   logic [19:0]   look;

   always_comb
   begin
      mr_sel   = {bus.bg[0], bus.ba};
      is_mr4   = (bus.cmd == CMD_MRS) && (mr_sel == `PRR_MR4);
      ent_soft = is_mr4 && bus.addr[`PRR_MR4_SOFT] && SUP_SOFT;
      ent_hard = is_mr4 && bus.addr[`PRR_MR4_HARD] && SUP_HARD;
      mr_exit  = is_mr4 && !bus.addr[`PRR_MR4_SOFT] && !bus.addr[`PRR_MR4_HARD];
      key_ok   = (bus.cmd == CMD_MRS) && (mr_sel == `PRR_MR0) && (bus.bg == 2'h0)
                 && (bus.addr[11:0] == prr_key(key_q));
      dq_low   = (bus.dq == `PRR_DQ_SELECT);
      commit   = (state_q == D_PRE) && (bus.cmd == CMD_PRE);
      look     = {i_look_ba, i_look_row};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Repair sequence
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         state_q <= D_IDLE;
         key_q   <= 2'h0;
         hard_q  <= 1'b0;
         wra_q   <= 1'b0;
         low_q   <= 1'b0;
         bg_q    <= 2'h0;
         beat_q  <= 2'h0;
         seed_q  <= 20'h00000;
         wcnt_q  <= '0;
      end
      else if (mr_exit)
         state_q <= D_IDLE;
      else
         unique case (state_q)
            D_IDLE:
               if (ent_soft || ent_hard)
               begin
                  state_q <= D_KEY;
                  key_q   <= 2'h0;
                  hard_q  <= ent_hard;
               end
            D_KEY:
               if (key_ok)
               begin
                  key_q <= key_q + 2'h1;
                  if (key_q == 2'h3)
                     state_q <= D_ARM;
               end
               // Bad key or any interruption: park silently until exit
               else if (bus.cmd != CMD_DES)
                  state_q <= D_HOLD;
            D_ARM:
               if (bus.cmd == CMD_ACT)
               begin
                  bg_q   <= bus.bg;
                  seed_q <= {bus.ba, bus.addr};
                  // One element per group, gone once fused
                  state_q <= hard_v_q[bus.bg] ? D_HOLD : D_ROW;
               end
            D_ROW:
               // Column address is not looked at
               if ((bus.cmd == CMD_WR) || (bus.cmd == CMD_WRA))
               begin
                  wra_q   <= (bus.cmd == CMD_WRA);
                  wcnt_q  <= WW'(WL - 1);
                  beat_q  <= 2'h0;
                  state_q <= (WL == 1) ? D_DATA : D_WLAT;
               end
            D_WLAT:
               if (wcnt_q == WW'(1))
                  state_q <= D_DATA;
               else
                  wcnt_q <= wcnt_q - WW'(1);
            D_DATA:
            begin
               beat_q <= beat_q + 2'h1;
               low_q  <= (beat_q == 2'h0) ? dq_low : (low_q && dq_low);
               // High on all four beats skips; mixed patterns also treated as skip
               if (beat_q == 2'h3)
                  state_q <= (low_q && dq_low) ? D_PRE : D_HOLD;
            end
            D_PRE:
               if (commit)
                  state_q <= D_HOLD;
            D_HOLD:
               state_q <= D_HOLD;
            default:
               state_q <= D_HOLD;
         endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Volatile repairs, lost on device reset
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         soft_v_q      <= 4'h0;
         retain_lost_q <= 1'b0;
      end
      else if (commit)
      begin
         soft_v_q[bg_q] <= !hard_q;
         if (!hard_q)
            soft_seed_q[bg_q] <= seed_q;
         if (hard_q && !wra_q)
            retain_lost_q <= 1'b1;
      end
   end

   // Fuses survive device reset; only power-up clears them
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_por_n)
         hard_v_q <= 4'h0;
      else if (commit && hard_q)
      begin
         hard_v_q[bg_q]    <= 1'b1;
         hard_seed_q[bg_q] <= seed_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Row lookup and support flag readout
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         hit_q   <= 1'b0;
         lost_q  <= 1'b0;
         dq_q    <= `PRR_DQ_IDLE;
         dq_oe_q <= 1'b0;
      end
      else
      begin
         hit_q  <= (soft_v_q[i_look_bg] && (soft_seed_q[i_look_bg] == look))
                   || (hard_v_q[i_look_bg] && (hard_seed_q[i_look_bg] == look));
         lost_q <= soft_v_q[i_look_bg]
                   && (((soft_seed_q[i_look_bg] ^ look) & ~`PRR_ASSOC_MASK) == 20'h00000);
         dq_oe_q <= (bus.cmd == CMD_MPR);
         dq_q    <= `PRR_DQ_IDLE;
         if (bus.cmd == CMD_MPR)
         begin
            dq_q                <= 8'h00;
            dq_q[`PRR_MPR_HARD] <= SUP_HARD;
            dq_q[`PRR_MPR_SOFT] <= SUP_SOFT;
         end
      end
   end

   assign o_look_hit    = hit_q;
   assign o_look_lost   = lost_q;
   assign o_soft_map    = soft_v_q;
   assign o_hard_map    = hard_v_q;
   assign o_retain_lost = retain_lost_q;
   assign bus.dev_dq_o  = dq_q;
   assign bus.dev_dq_oe = dq_oe_q;
endmodule

// >>> verilog/prr_ctl_end.sv
// Controller side row repair sequencer with a small register port
// How it works
// - Support flags read from page bits 7, 6
// - Hard: wait programming time, then exit time
// - Hard: settle new address after exit
// - Soft repairs vanish on device reset
// - One element per group; fuse blocks soft
// - Used-up group ignores whole sequence
// - MR4 bit 5 soft, bit 13 hard
// - Exit last repair mode before new entry
// - Soft repairs cleared before hard entry
// - Banks closed, DBI/CRC off, then entry
// - Four guard key MR0s, mode delay apart
// - ACT gives target; write column ignored
// - Four low beats select; high skips
// - Recovery, precharge, then latch wait
// - Clear bit, then mode register delay
// - No refresh inside soft repair
// - Latest soft repair per group wins
// - Seed and associated rows lose data
// - Backing up rows left to software
// - Soft repair outside refresh window
// - Retention only with WRA and refreshes
// - Verification readback left to software
// - Broken key: no repair, no lockup
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "prr_defines.svh"
module prr_ctl_end
   import prr_pkg::*;
#(
   parameter int T_MOD_CK  = 24,
   parameter int T_RCD_CK  = 2,
   parameter int WL        = 9,
   parameter int T_WR_CK   = 2,
   parameter int T_REFI_CK = 78,
   parameter int T_RFC_CK  = 4,
   parameter int T_PGM_CK  = `PRR_T_PGM_CK
)(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   prr_if.ctl               bus
);
   localparam int CW = 24;

   prr_cstate_t state_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] ref_q;
   logic [1:0]    key_q;
   logic [1:0]    beat_q;
   prr_cmd_t      cmd_q;
   logic [1:0]    bg_q;
   logic [1:0]    ba_q;
   logic [17:0]   addr_q;
   logic [7:0]    dq_q;
   logic          dq_oe_q;
   logic          hard_q;
   logic          wra_q;
   logic          sel_q;
   logic [21:0]   target_q;
   logic          done_q;
   logic          refused_q;
   logic          soft_done_q;
   logic [7:0]    flags_q;
   logic [31:0]   rdata_q;
   logic          ctrl_wr;
   logic          go_rep;
   logic          go_mpr;
   logic          refuse;
   logic          finish;

   always_comb
   begin
      ctrl_wr = i_wr && (i_addr == `PRR_REG_CTRL) && (state_q == C_IDLE);
      go_mpr  = ctrl_wr && i_wdata[`PRR_CTRL_MPR];
      // Soft repairs must be gone before fusing
      refuse  = ctrl_wr && !go_mpr && i_wdata[`PRR_CTRL_START]
                && i_wdata[`PRR_CTRL_HARD] && soft_done_q;
      go_rep  = ctrl_wr && !go_mpr && i_wdata[`PRR_CTRL_START] && !refuse;
      finish  = ((state_q == C_POST) || (state_q == C_MPR)) && (cnt_q == '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         hard_q   <= 1'b0;
         wra_q    <= 1'b0;
         sel_q    <= 1'b0;
         target_q <= 22'h000000;
         rdata_q  <= 32'h00000000;
      end
      else
      begin
         if (go_rep)
         begin
            hard_q <= i_wdata[`PRR_CTRL_HARD];
            wra_q  <= i_wdata[`PRR_CTRL_WRA];
            sel_q  <= i_wdata[`PRR_CTRL_SEL];
         end
         if (i_wr && (i_addr == `PRR_REG_TARGET) && (state_q == C_IDLE))
            target_q <= i_wdata[21:0];
         rdata_q <= 32'h00000000;
         if (i_rd)
            unique case (i_addr)
               `PRR_REG_CTRL:   rdata_q <= {29'h0, sel_q, wra_q, hard_q};
               `PRR_REG_TARGET: rdata_q <= {10'h000, target_q};
               `PRR_REG_STATUS: rdata_q <= {29'h0, refused_q, done_q, state_q != C_IDLE};
               `PRR_REG_FLAGS:  rdata_q <= {24'h000000, flags_q};
               default:         rdata_q <= 32'h00000000;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, set wins over clear
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         done_q      <= 1'b0;
         refused_q   <= 1'b0;
         soft_done_q <= 1'b0;
         flags_q     <= 8'h00;
      end
      else
      begin
         if (go_rep || go_mpr)
         begin
            done_q    <= 1'b0;
            refused_q <= 1'b0;
         end
         if (ctrl_wr && i_wdata[`PRR_CTRL_CLRSOFT])
            soft_done_q <= 1'b0;
         if (go_rep && !i_wdata[`PRR_CTRL_HARD])
            soft_done_q <= 1'b1;
         if (refuse)
            refused_q <= 1'b1;
         if (finish)
            done_q <= 1'b1;
         if ((state_q == C_MPR) && (cnt_q == '0))
            flags_q <= bus.dq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencer; banks are closed and DBI/CRC never enabled here
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         state_q <= C_IDLE;
         cnt_q   <= '0;
         ref_q   <= '0;
         key_q   <= 2'h0;
         beat_q  <= 2'h0;
         cmd_q   <= CMD_DES;
         bg_q    <= 2'h0;
         ba_q    <= 2'h0;
         addr_q  <= 18'h00000;
         dq_q    <= `PRR_DQ_IDLE;
         dq_oe_q <= 1'b0;
      end
      else
      begin
         cmd_q  <= CMD_DES;
         bg_q   <= 2'h0;
         ba_q   <= 2'h0;
         addr_q <= 18'h00000;
         if (cnt_q != '0)
            cnt_q <= cnt_q - CW'(1);
         if (ref_q != '0)
            ref_q <= ref_q - CW'(1);
         unique case (state_q)
            C_IDLE:
               if (go_mpr)
               begin
                  cmd_q   <= CMD_MPR;
                  cnt_q   <= CW'(1);
                  state_q <= C_MPR;
               end
               // Every sequence ends in its own exit, so entry is always clean
               else if (go_rep)
                  state_q <= C_ENTER;
            C_ENTER:
            begin
               cmd_q  <= CMD_MRS;
               bg_q   <= 2'h1;
               addr_q[hard_q ? `PRR_MR4_HARD : `PRR_MR4_SOFT] <= 1'b1;
               cnt_q   <= CW'(T_MOD_CK - 1);
               key_q   <= 2'h0;
               state_q <= C_KEY;
            end
            C_KEY:
               if (cnt_q == '0)
               begin
                  cmd_q        <= CMD_MRS;
                  addr_q[11:0] <= prr_key(key_q);
                  cnt_q        <= CW'(T_MOD_CK - 1);
                  key_q        <= key_q + 2'h1;
                  if (key_q == 2'h3)
                     state_q <= C_ACT;
               end
            C_ACT:
               if (cnt_q == '0)
               begin
                  cmd_q   <= CMD_ACT;
                  bg_q    <= target_q[21:20];
                  ba_q    <= target_q[19:18];
                  addr_q  <= target_q[17:0];
                  cnt_q   <= CW'(T_RCD_CK - 1);
                  state_q <= C_WR;
               end
            C_WR:
               if (cnt_q == '0)
               begin
                  cmd_q   <= (hard_q && wra_q) ? CMD_WRA : CMD_WR;
                  ba_q    <= target_q[19:18];
                  bg_q    <= target_q[21:20];
                  cnt_q   <= CW'(WL - 1);
                  state_q <= C_WLAT;
               end
            C_WLAT:
               if (cnt_q == '0)
               begin
                  dq_oe_q <= 1'b1;
                  dq_q    <= sel_q ? `PRR_DQ_SELECT : `PRR_DQ_IDLE;
                  beat_q  <= 2'h0;
                  state_q <= C_DQ;
               end
            C_DQ:
            begin
               beat_q <= beat_q + 2'h1;
               if (beat_q == 2'h3)
               begin
                  dq_oe_q <= 1'b0;
                  dq_q    <= `PRR_DQ_IDLE;
                  cnt_q   <= hard_q ? CW'(T_PGM_CK - 1) : CW'(T_WR_CK - 1);
                  ref_q   <= CW'(T_REFI_CK - 1);
                  state_q <= C_REC;
               end
            end
            C_REC:
               if (cnt_q == '0)
               begin
                  cmd_q   <= CMD_PRE;
                  ba_q    <= target_q[19:18];
                  bg_q    <= target_q[21:20];
                  cnt_q   <= hard_q ? CW'(`PRR_T_EXIT_CK - 1)
                                    : CW'(`PRR_T_LATCH_CK - 1);
                  state_q <= C_EXIT;
               end
               // Refresh only while fusing with WRA, never in a soft repair
               else if (hard_q && wra_q && (ref_q == '0)
                        && (cnt_q > CW'(T_RFC_CK)))
               begin
                  cmd_q <= CMD_REF;
                  ref_q <= CW'(T_REFI_CK - 1);
               end
            C_EXIT:
               if (cnt_q == '0)
               begin
                  cmd_q   <= CMD_MRS;
                  bg_q    <= 2'h1;
                  cnt_q   <= hard_q ? CW'(`PRR_T_PGMPST_CK - 1)
                                    : CW'(T_MOD_CK - 1);
                  state_q <= C_POST;
               end
            C_POST:
               // Readback check of the row is up to software
               if (cnt_q == '0)
                  state_q <= C_IDLE;
            C_MPR:
               if (cnt_q == '0)
                  state_q <= C_IDLE;
         endcase
      end
   end

   assign o_rdata       = rdata_q;
   assign bus.cmd       = cmd_q;
   assign bus.bg        = bg_q;
   assign bus.ba        = ba_q;
   assign bus.addr      = addr_q;
   assign bus.ctl_dq_o  = dq_q;
   assign bus.ctl_dq_oe = dq_oe_q;
endmodule

// >>> testbench/prr_bus_sva.sv
// Assertions on the repair command, address and DQ bus
`timescale 1ns/1ns
module prr_bus_sva
   import prr_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_rst_n,
   input wire prr_cmd_t    cmd,
   input wire logic [1:0]  bg,
   input wire logic [1:0]  ba,
   input wire logic [17:0] addr,
   input wire logic [7:0]  ctl_dq_o,
   input wire logic        ctl_dq_oe,
   input wire logic [7:0]  dev_dq_o,
   input wire logic        dev_dq_oe
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic mr4 = cmd == CMD_MRS && {bg[0], ba} == 3'h4;
   wire logic mr0 = cmd == CMD_MRS && {bg, ba} == 4'h0;
   logic      soft_q;
   ////////////////////////////////////////
   // Tracks soft mode so refresh inside it is caught
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         soft_q <= 1'b0;
      else if (mr4)
         soft_q <= addr[5];
   end
   AST_MPR_ANSWER: assert property (
      cmd == CMD_MPR |=> dev_dq_oe && dev_dq_o[7:6] == 2'h3)
      else $error("support page not driven after page read");
   AST_DEV_QUIET: assert property (dev_dq_oe |-> $past(cmd) == CMD_MPR)
      else $error("device drove DQ without a page read");
   AST_ENTRY_KEY: assert property (
      mr4 && (addr[5] || addr[13]) |-> ##24 mr0 && addr[11:0] == 12'hCFF)
      else $error("first key not one mode delay after entry");
   AST_KEY_STEP: assert property (
      mr0 && addr[11:0] == 12'hCFF |-> ##24 mr0 && addr[11:0] == 12'h7FF
      ##24 mr0 && addr[11:0] == 12'hBFF ##24 mr0 && addr[11:0] == 12'h3FF ##24 cmd == CMD_ACT)
      else $error("key sequence order or spacing wrong");
   AST_ACT_WR: assert property (cmd == CMD_ACT |-> ##2 cmd inside {CMD_WR, CMD_WRA})
      else $error("write not two cycles after activate");
   AST_BURST: assert property (
      cmd inside {CMD_WR, CMD_WRA} |-> ##9 ctl_dq_oe [*4] ##1 !ctl_dq_oe)
      else $error("DQ burst not four beats after write latency");
   AST_DQ_LEVEL: assert property (ctl_dq_oe |-> ctl_dq_o inside {8'h00, 8'hFF})
      else $error("DQ burst level mixed");
   AST_EXIT: assert property (cmd == CMD_PRE |=> mr4 && !addr[5] && !addr[13])
      else $error("mode exit not right after precharge");
   AST_NO_REF_SOFT: assert property (soft_q |-> cmd != CMD_REF)
      else $error("refresh inside soft repair");
endmodule

// >>> testbench/dram_post_package_row_repair_tb.sv
// Bench joining controller and DRAM repair ends
`timescale 1ns/1ns
module dram_post_package_row_repair_tb;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_por_n = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic [21:0] i_look = 22'h0;
   logic        o_look_hit;
   logic        o_look_lost;
   logic [3:0]  o_soft_map;
   logic [3:0]  o_hard_map;
   logic        o_retain_lost;
   logic [31:0] rd_q;
   int          num_errors = 0;
   int          compares = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   prr_if prr_if_inst ();
   // Short programming time keeps the hard runs brief
   prr_ctl_end #(.T_PGM_CK(200)) prr_ctl_end_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .bus(prr_if_inst));
   prr_dram_end prr_dram_end_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
      .bus(prr_if_inst), .i_look_bg(i_look[21:20]), .i_look_ba(i_look[19:18]),
      .i_look_row(i_look[17:0]), .o_look_hit(o_look_hit), .o_look_lost(o_look_lost),
      .o_soft_map(o_soft_map), .o_hard_map(o_hard_map), .o_retain_lost(o_retain_lost));
   prr_bus_sva prr_bus_sva_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .cmd(prr_if_inst.cmd), .bg(prr_if_inst.bg), .ba(prr_if_inst.ba),
      .addr(prr_if_inst.addr), .ctl_dq_o(prr_if_inst.ctl_dq_o),
      .ctl_dq_oe(prr_if_inst.ctl_dq_oe), .dev_dq_o(prr_if_inst.dev_dq_o),
      .dev_dq_oe(prr_if_inst.dev_dq_oe));
   ////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      rd_q = o_rdata;
   endtask
   // Start an operation and poll status until done, bounded
   task automatic run(input logic [21:0] tgt, input logic [31:0] ctrl);
      int n;
      reg_wr(4'h4, {10'h0, tgt});
      reg_wr(4'h0, ctrl);
      n = 0;
      rd_q = 32'h0;
      while (rd_q[1] !== 1'b1 && n < 3000)
      begin
         reg_rd(4'h8);
         n++;
      end
      check("done", 32'h1, {31'h0, rd_q[1]});
      if (rd_q[1] !== 1'b1)
         end_sim();
   endtask
   task automatic look(input logic [21:0] t, input logic hit, input logic lost);
      @(posedge i_ref_clk);
      i_look <= t;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      check("look_hit", {31'h0, hit}, {31'h0, o_look_hit});
      check("look_lost", {31'h0, lost}, {31'h0, o_look_lost});
   endtask
   ////////////////////////////////////////
   task automatic s_mpr;
      run(22'h0, 32'h10);
      reg_rd(4'hC);
      check("flags", 32'h3, {30'h0, rd_q[7:6]});
   endtask
   task automatic s_soft;
      run(22'h040123, 32'h9);
      check("soft_map", 32'h1, {28'h0, o_soft_map});
      look(22'h040123, 1'b1, 1'b1);
      run(22'h300055, 32'h1);
      check("soft_map", 32'h1, {28'h0, o_soft_map});
      run(22'h080200, 32'h9);
      look(22'h040123, 1'b0, 1'b0);
      look(22'h0D0200, 1'b0, 1'b1);
      look(22'h080204, 1'b0, 1'b0);
   endtask
   task automatic s_refuse_reset;
      reg_wr(4'h0, 32'h3);
      reg_rd(4'h8);
      check("refused", 32'h1, {31'h0, rd_q[2]});
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(negedge i_ref_clk);
      check("soft_map", 32'h0, {28'h0, o_soft_map});
      look(22'h080200, 1'b0, 1'b0);
   endtask
   task automatic s_hard;
      run(22'h100321, 32'hF);
      check("hard_map", 32'h2, {28'h0, o_hard_map});
      check("retain", 32'h0, {31'h0, o_retain_lost});
      look(22'h100321, 1'b1, 1'b0);
      run(22'h100400, 32'h9);
      check("soft_map", 32'h0, {28'h0, o_soft_map});
      reg_wr(4'h0, 32'h20);
      run(22'h200077, 32'hB);
      check("hard_map", 32'h6, {28'h0, o_hard_map});
      check("retain", 32'h1, {31'h0, o_retain_lost});
      reg_rd(4'h0);
      check("ctrl", 32'h5, rd_q);
      reg_rd(4'h4);
      check("target", 32'h200077, rd_q);
   endtask
   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      i_por_n <= 1'b1;
      s_mpr();
      s_soft();
      s_refuse_reset();
      s_hard();
      end_sim();
   end
endmodule
